// file: core/timer1_pwm_capture.sv
// Timer/counter 1 with edge capture and dual phase-correct PWM.
// Assumes the prescaler delivers a one-cycle timer tick enable and the
// global interrupt enable arrives as a level from the CPU.
`timescale 1ns/1ps
module timer1_pwm_capture #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Register port
	input  wire logic [3:0]       addr,
	input  wire logic [7:0]       wdata,
	input  wire logic             wr_stb,
	input  wire logic             rd_stb,
	output logic      [7:0]       rdata,
	// Prescaler tick and global interrupt enable
	input  wire logic             timer_tick,
	input  wire logic             global_irq_en,
	// Pins
	input  wire logic             capture_pin,
	output logic                  pwm_out_a,
	output logic                  pwm_out_b,
	output logic                  pwm_oe_n_a,
	output logic                  pwm_oe_n_b,
	output logic                  irq
);
	////////////////////////////////////////////////////////////////////////
	timer1_pkg::bus_req_t req;
	assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

	logic [7:0]       timer_control_a;
	logic [7:0]       timer_control_b;
	logic [CNT_W-1:0] counter_value;
	logic             count_down;
	logic [9:0]       cmp_buf_a;
	logic [9:0]       cmp_buf_b;
	logic [9:0]       cmp_act_a;
	logic [9:0]       cmp_act_b;
	logic [CNT_W-1:0] capture_snapshot;
	logic [7:0]       temp_reg;
	logic [3:0]       flags_reg;
	logic [3:0]       irq_en_reg;
	logic [1:0]       cap_sync;
	logic             cap_prev;
	logic             pend_a;
	logic             pend_b;

	wire [1:0] pwm_sel = timer_control_a[timer1_pkg::PWM_SEL_LSB +: 2];
	wire pwm_on = (pwm_sel != 2'h0);
	wire capture_edge_select = timer_control_b[timer1_pkg::EDGE_BIT];
	wire [2:0] clock_select = timer_control_b[timer1_pkg::CLKSEL_LSB +: 3];
	wire tick = timer_tick && (clock_select != timer1_pkg::CLKSEL_STOP);
	wire undivided = (clock_select == timer1_pkg::CLKSEL_UNDIV);
	timer1_pkg::out_mode_t output_mode_a;
	timer1_pkg::out_mode_t output_mode_b;
	assign output_mode_a = timer1_pkg::out_mode_t'(timer_control_a[timer1_pkg::MODE_A_LSB +: 2]);
	assign output_mode_b = timer1_pkg::out_mode_t'(timer_control_a[timer1_pkg::MODE_B_LSB +: 2]);

	// Ceiling from resolution select
	function automatic logic [9:0] top_of(input logic [1:0] sel);
		unique case (sel)
			2'h1:    top_of = timer1_pkg::TOP_8;
			2'h2:    top_of = timer1_pkg::TOP_9;
			default: top_of = timer1_pkg::TOP_10;
		endcase
	endfunction : top_of

	// Write decode shared by every register that software can load except the temp byte
	function automatic logic wr_at(input timer1_pkg::bus_req_t r, input logic [3:0] a);
		wr_at = r.wr && (r.addr == a);
	endfunction : wr_at

	// Read decode for the reads that also load the shared temp byte
	function automatic logic rd_at(input timer1_pkg::bus_req_t r, input logic [3:0] a);
		rd_at = r.rd && (r.addr == a);
	endfunction : rd_at

	wire [9:0] top = top_of(pwm_sel);
	wire [9:0] cnt10 = counter_value[9:0];
	wire at_top = pwm_on && (cnt10 == top);
	wire at_zero = (cnt10 == timer1_pkg::ZERO10);

	////////////////////////////////////////////////////////////////////////
	// Control registers, one process each
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			timer_control_a <= timer1_pkg::RESET_BYTE;
		end else if (wr_at(req, timer1_pkg::ADDR_CTRL_A)) begin
			timer_control_a <= req.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			timer_control_b <= timer1_pkg::RESET_BYTE;
		end else if (wr_at(req, timer1_pkg::ADDR_CTRL_B)) begin
			timer_control_b <= req.wdata;
		end
	end

	// Enables only gate the request; flags still set while disabled
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_en_reg <= 4'h0;
		end else if (wr_at(req, timer1_pkg::ADDR_IRQ_EN)) begin
			irq_en_reg <= req.wdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter: up/down in PWM mode, plain up count otherwise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			counter_value <= '0;
			count_down    <= 1'b0;
		end else if (wr_at(req, timer1_pkg::ADDR_CNT_HI)) begin
			counter_value <= CNT_W'({req.wdata, temp_reg});
			count_down    <= 1'b0;
		end else if (tick) begin
			if (pwm_on) begin
				if (!count_down) begin
					if (cnt10 == top) begin
						count_down    <= 1'b1;
						counter_value <= counter_value - 1'b1;
					end else begin
						counter_value <= counter_value + 1'b1;
					end
				end else if (at_zero) begin
					count_down    <= 1'b0;
					counter_value <= counter_value + 1'b1;
				end else begin
					counter_value <= counter_value - 1'b1;
				end
			end else begin
				counter_value <= counter_value + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare buffers; active copies latch at the ceiling in PWM mode
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmp_buf_a <= '0;
		end else if (wr_at(req, timer1_pkg::ADDR_CMPA_HI)) begin
			cmp_buf_a <= {req.wdata[1:0], temp_reg};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmp_buf_b <= '0;
		end else if (wr_at(req, timer1_pkg::ADDR_CMPB_HI)) begin
			cmp_buf_b <= {req.wdata[1:0], temp_reg};
		end
	end

	// Latching only at the ceiling keeps pulse widths whole
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmp_act_a <= '0;
		end else if (!pwm_on || (tick && at_top)) begin
			cmp_act_a <= cmp_buf_a;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmp_act_b <= '0;
		end else if (!pwm_on || (tick && at_top)) begin
			cmp_act_b <= cmp_buf_b;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capture: two-stage synchroniser then edge compare of two samples
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cap_sync <= 2'h0;
		end else begin
			cap_sync <= {cap_sync[0], capture_pin};
		end
	end

	// Reset level matches the idle pin, so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cap_prev <= 1'b0;
		end else begin
			cap_prev <= cap_sync[1];
		end
	end

	wire cap_edge = capture_edge_select ? (cap_sync[1] && !cap_prev)
	                                    : (!cap_sync[1] && cap_prev);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			capture_snapshot <= '0;
		end else if (cap_edge) begin
			capture_snapshot <= counter_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared temp byte: written by counter and compare low-byte writes, loaded by counter and capture low-byte reads
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			temp_reg <= timer1_pkg::RESET_BYTE;
		end else if (rd_at(req, timer1_pkg::ADDR_CAP_LO)) begin
			temp_reg <= capture_snapshot[15:8];
		end else if (rd_at(req, timer1_pkg::ADDR_CNT_LO)) begin
			temp_reg <= counter_value[15:8];
		end else if (req.wr) begin
			if (req.addr == timer1_pkg::ADDR_CNT_LO || req.addr == timer1_pkg::ADDR_CMPA_LO ||
			    req.addr == timer1_pkg::ADDR_CMPB_LO)
				temp_reg <= req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare matches, only on timer ticks
	wire match_a = tick && pwm_on && (cnt10 == cmp_act_a);
	wire match_b = tick && pwm_on && (cnt10 == cmp_act_b);

	// Next level for one channel on a match. At the ceiling the up and
	// down matches coincide: undivided gives no pulse, prescaled holds the
	// active level until the next ceiling.
	function automatic logic [1:0] pwm_step(input timer1_pkg::out_mode_t m,
	                                        input logic cur, input logic pend,
	                                        input logic hit, input logic dn,
	                                        input logic ceil, input logic undiv);
		logic up_lvl;
		up_lvl = (m == timer1_pkg::OUT_INV);
		pwm_step = {cur, 1'b0};
		if (hit) begin
			if (ceil) begin
				if (undiv)
					pwm_step = {up_lvl, 1'b0};
				else if (pend)
					pwm_step = {up_lvl, 1'b0};
				else
					pwm_step = {~up_lvl, 1'b1};
			end else begin
				pwm_step = {dn ? ~up_lvl : up_lvl, 1'b0};
			end
		end
	endfunction : pwm_step

	// The bottom turn counts as an up-count match, so zero gives a steady level
	wire dn_match = count_down && !at_zero;

	wire [1:0] step_a = pwm_step(output_mode_a, pwm_out_a, pend_a, match_a, dn_match,
	                             at_top, undivided);
	wire [1:0] step_b = pwm_step(output_mode_b, pwm_out_b, pend_b, match_b, dn_match,
	                             at_top, undivided);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwm_out_a <= 1'b0;
			pend_a    <= 1'b0;
		end else begin
			{pwm_out_a, pend_a} <= step_a;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwm_out_b <= 1'b0;
			pend_b    <= 1'b0;
		end else begin
			{pwm_out_b, pend_b} <= step_b;
		end
	end

	// Pin driven only in modes 10 and 11
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwm_oe_n_a <= 1'b1;
		end else begin
			pwm_oe_n_a <= !(pwm_on && output_mode_a[1]);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwm_oe_n_b <= 1'b1;
		end else begin
			pwm_oe_n_b <= !(pwm_on && output_mode_b[1]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags: hardware set wins over a write-one clear
	logic [3:0] flag_set;
	always_comb begin
		flag_set = 4'h0;
		flag_set[timer1_pkg::FLAG_OVF] = tick && (pwm_on ? (at_zero && count_down)
		                                         : (&counter_value));
		flag_set[timer1_pkg::FLAG_CMPA] = match_a;
		flag_set[timer1_pkg::FLAG_CMPB] = match_b;
		flag_set[timer1_pkg::FLAG_CAP] = cap_edge;
	end

	wire [3:0] flag_clr = wr_at(req, timer1_pkg::ADDR_FLAGS) ? req.wdata[3:0] : 4'h0;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flags_reg <= 4'h0;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= global_irq_en && |(flags_reg & irq_en_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata <= timer1_pkg::RESET_BYTE;
		end else if (req.rd) begin
			unique case (req.addr)
				timer1_pkg::ADDR_CTRL_A:  rdata <= timer_control_a;
				timer1_pkg::ADDR_CTRL_B:  rdata <= timer_control_b;
				timer1_pkg::ADDR_CNT_LO:  rdata <= counter_value[7:0];
				timer1_pkg::ADDR_CNT_HI:  rdata <= temp_reg;
				timer1_pkg::ADDR_CMPA_LO: rdata <= cmp_buf_a[7:0];
				timer1_pkg::ADDR_CMPA_HI: rdata <= {6'h00, cmp_buf_a[9:8]};
				timer1_pkg::ADDR_CMPB_LO: rdata <= cmp_buf_b[7:0];
				timer1_pkg::ADDR_CMPB_HI: rdata <= {6'h00, cmp_buf_b[9:8]};
				timer1_pkg::ADDR_CAP_LO:  rdata <= capture_snapshot[7:0];
				timer1_pkg::ADDR_CAP_HI:  rdata <= temp_reg;
				timer1_pkg::ADDR_FLAGS:   rdata <= {3'h0, irq, flags_reg};
				timer1_pkg::ADDR_IRQ_EN:  rdata <= {4'h0, irq_en_reg};
				default:                  rdata <= 8'h00;
			endcase
		end
	end
endmodule : timer1_pwm_capture

// file: core/timer1_pkg.sv
// Package for the 16-bit timer capture and PWM block.
// Assumes an 8-bit register port with word-indexed byte registers.
package timer1_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CTRL_A    = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B    = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO    = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI    = 4'h3;
	localparam logic [3:0] ADDR_CMPA_LO   = 4'h4;
	localparam logic [3:0] ADDR_CMPA_HI   = 4'h5;
	localparam logic [3:0] ADDR_CMPB_LO   = 4'h6;
	localparam logic [3:0] ADDR_CMPB_HI   = 4'h7;
	localparam logic [3:0] ADDR_CAP_LO    = 4'h8;
	localparam logic [3:0] ADDR_CAP_HI    = 4'h9;
	localparam logic [3:0] ADDR_FLAGS     = 4'hA;
	localparam logic [3:0] ADDR_IRQ_EN    = 4'hB;

	// timer_control_a fields
	localparam int MODE_A_LSB = 6;
	localparam int MODE_B_LSB = 4;
	localparam int PWM_SEL_LSB = 0;
	// timer_control_b fields
	localparam int EDGE_BIT   = 6;
	localparam int CLKSEL_LSB = 0;
	// Flag and enable bit positions
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMPA = 1;
	localparam int FLAG_CMPB = 2;
	localparam int FLAG_CAP = 3;
	localparam int FLAG_IRQ = 4;

	localparam logic [2:0] CLKSEL_STOP   = 3'h0;
	localparam logic [2:0] CLKSEL_UNDIV  = 3'h1;

	localparam logic [9:0] TOP_8  = 10'h0FF;
	localparam logic [9:0] TOP_9  = 10'h1FF;
	localparam logic [9:0] TOP_10 = 10'h3FF;
	localparam logic [9:0] ZERO10 = 10'h000;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef enum logic [1:0] {
		OUT_OFF0   = 2'h0,
		OUT_OFF1   = 2'h1,
		OUT_NONINV = 2'h2,
		OUT_INV    = 2'h3
	} out_mode_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;
endpackage : timer1_pkg

// file: dv/timer1_pwm_capture_asserts.sv
// Checker for the timer capture and PWM block, bound to its top module.
// Assumes control and interrupt enable registers reset to zero.
`timescale 1ns/1ps
module timer1_pwm_capture_asserts (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst_n,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] rdata,
	// Interrupt and pin enables
	input wire logic       global_irq_en,
	input wire logic       irq,
	input wire logic       pwm_oe_n_a,
	input wire logic       pwm_oe_n_b
);
	logic [7:0] ctl_reg;
	logic [3:0] ien_reg;
	logic [1:0] age_reg;
	logic       ctl_wr;
	logic       ien_wr;
	assign ctl_wr = wr_stb && addr == timer1_pkg::ADDR_CTRL_A;
	assign ien_wr = wr_stb && addr == timer1_pkg::ADDR_IRQ_EN;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Mirror of control writes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctl_reg <= 8'h00;
			ien_reg <= 4'h0;
		end else if (ctl_wr) begin
			ctl_reg <= wdata;
		end else if (ien_wr) begin
			ien_reg <= wdata[3:0];
		end
	end
	// Age gives registered outputs time to follow a control write
	always_ff @(posedge mclk) begin
		if (!rst_n || ctl_wr || ien_wr) begin
			age_reg <= 2'h0;
		end else if (age_reg != 2'h3) begin
			age_reg <= age_reg + 2'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_RDATA_HOLDS: assert property ($past(rst_n) && !$past(rd_stb) |-> $stable(rdata))
		else $error("read data moved without a read");
	AST_UNMAPPED_ZERO: assert property ($past(rd_stb) && $past(addr) > 4'hB |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_OE_A_OFF: assert property (age_reg == 2'h3 && !ctl_reg[7] |-> pwm_oe_n_a)
		else $error("channel A driven in a disconnected mode");
	AST_OE_A_ON: assert property (age_reg == 2'h3 && ctl_reg[7] && ctl_reg[1:0] != 2'h0 |-> !pwm_oe_n_a)
		else $error("channel A not driven in PWM");
	AST_OE_B_OFF: assert property (age_reg == 2'h3 && !ctl_reg[5] |-> pwm_oe_n_b)
		else $error("channel B driven in a disconnected mode");
	AST_OE_B_ON: assert property (age_reg == 2'h3 && ctl_reg[5] && ctl_reg[1:0] != 2'h0 |-> !pwm_oe_n_b)
		else $error("channel B not driven in PWM");
	AST_IRQ_GLOBAL: assert property (!global_irq_en [*2] |-> !irq)
		else $error("interrupt with global enable off");
	AST_IRQ_NO_ENABLE: assert property (age_reg == 2'h3 && ien_reg == 4'h0 |-> !irq)
		else $error("interrupt with all enables off");
	cover property (rd_stb && addr == timer1_pkg::ADDR_CAP_HI);
	cover property ($rose(irq));
	cover property (!pwm_oe_n_a && !pwm_oe_n_b);
endmodule : timer1_pwm_capture_asserts
////////////////////////////////////////////////////////////////////////////////
bind timer1_pwm_capture timer1_pwm_capture_asserts u_timer1_pwm_capture_asserts (
	.mclk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.global_irq_en, .irq, .pwm_oe_n_a, .pwm_oe_n_b);

// file: dv/pwm_load_model.sv
// Far-side model: capture signal source and two pulled-down PWM loads.
// Assumes the bench sets the wanted capture level at a rising clock edge.
`timescale 1ns/1ps
module pwm_load_model (
	// Clock
	input  wire logic        mclk,
	// Capture source
	input  wire logic        cap_level,
	input  wire logic        slow,
	output logic             capture_pin,
	// PWM pins and load counters
	input  wire logic        pwm_out_a,
	input  wire logic        pwm_out_b,
	input  wire logic        pwm_oe_n_a,
	input  wire logic        pwm_oe_n_b,
	input  wire logic        clr,
	output logic             pin_a,
	output logic      [11:0] high_a,
	output logic      [11:0] high_b
);
	logic [2:0] dly_reg = 3'h0;
	logic       pin_b;
	// Slow source lags by three cycles, like a long cable
	always_ff @(posedge mclk) dly_reg <= {dly_reg[1:0], cap_level};
	assign capture_pin = slow ? dly_reg[2] : cap_level;
	// A released pin falls to the load's pull-down
	assign pin_a = pwm_oe_n_a ? 1'b0 : pwm_out_a;
	assign pin_b = pwm_oe_n_b ? 1'b0 : pwm_out_b;
	always_ff @(posedge mclk) begin
		high_a <= clr ? 12'h000 : high_a + {11'h000, pin_a};
		high_b <= clr ? 12'h000 : high_b + {11'h000, pin_b};
	end
endmodule : pwm_load_model

// file: dv/timer1_pwm_input_capture_bench.sv
// Self-checking bench for the timer capture and PWM block.
// Assumes no timer tick during capture tests, a tick every cycle for PWM.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module timer1_pwm_input_capture_bench;
	logic        mclk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, clr = 1'b0;
	logic        timer_tick = 1'b0, global_irq_en = 1'b0, cap_level = 1'b0, slow = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00, rdata;
	logic        capture_pin, pwm_out_a, pwm_out_b, pwm_oe_n_a, pwm_oe_n_b, irq, pin_a;
	logic [11:0] high_a, high_b;
	int          mismatches = 0, samples_checked = 0, cycles = 0, t0;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	timer1_pwm_capture u_timer1_pwm_capture (.mclk, .rst_n, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .timer_tick, .global_irq_en, .capture_pin, .pwm_out_a,
		.pwm_out_b, .pwm_oe_n_a, .pwm_oe_n_b, .irq);
	pwm_load_model u_pwm_load_model (.mclk, .cap_level, .slow, .capture_pin, .pwm_out_a,
		.pwm_out_b, .pwm_oe_n_a, .pwm_oe_n_b, .clr, .pin_a, .high_a, .high_b);
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr
	// Low byte first so the high write commits both halves
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 4'h1, d[15:8]);
	endtask : wr16
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		`CHK(rdata & m, e)
	endtask : rd
	task automatic window();
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (510) @(posedge mclk);
		@(negedge mclk);
	endtask : window
	task automatic rise();
		@(posedge mclk iff !pin_a);
		@(posedge mclk iff pin_a);
	endtask : rise
	////////////////////////////////////////////////////////////////////////////////
	// Counter held still so the snapshot value is known exactly
	task automatic capture_tests();
		wr(timer1_pkg::ADDR_CTRL_B, 8'h40);
		wr16(timer1_pkg::ADDR_CNT_LO, 16'hA55A);
		cap_level <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(timer1_pkg::ADDR_CAP_LO, 8'h5A);
		rd(timer1_pkg::ADDR_CAP_HI, 8'hA5);
		rd(timer1_pkg::ADDR_FLAGS, 8'h08, 8'h08);
		wr(timer1_pkg::ADDR_FLAGS, 8'h08);
		rd(timer1_pkg::ADDR_FLAGS, 8'h00, 8'h08);
		wr16(timer1_pkg::ADDR_CAP_LO, 16'h2211);
		wr16(timer1_pkg::ADDR_CNT_LO, 16'h0F3C);
		cap_level <= 1'b0;
		repeat (6) @(posedge mclk);
		rd(timer1_pkg::ADDR_CAP_LO, 8'h5A);
		rd(4'hC, 8'h00);
		wr(timer1_pkg::ADDR_CTRL_B, 8'h00);
		slow <= 1'b1;
		cap_level <= 1'b1;
		repeat (8) @(posedge mclk);
		cap_level <= 1'b0;
		repeat (8) @(posedge mclk);
		rd(timer1_pkg::ADDR_CAP_HI, 8'hA5);
		rd(timer1_pkg::ADDR_CAP_LO, 8'h3C);
		rd(timer1_pkg::ADDR_CAP_HI, 8'h0F);
	endtask : capture_tests
	// Same compare on both channels, one inverted: highs add to a full period
	task automatic pwm_tests();
		timer_tick <= 1'b1;
		wr(timer1_pkg::ADDR_CTRL_B, 8'h01);
		wr16(timer1_pkg::ADDR_CMPA_LO, 16'hFC40);
		wr16(timer1_pkg::ADDR_CMPB_LO, 16'h0040);
		wr16(timer1_pkg::ADDR_CNT_LO, 16'h0000);
		wr(timer1_pkg::ADDR_CTRL_A, 8'hB1);
		repeat (600) @(posedge mclk);
		window();
		`CHK(high_a > 12'h07D && high_a < 12'h083, 1'b1)
		`CHK(high_a + high_b, 12'h1FE)
		wr16(timer1_pkg::ADDR_CMPA_LO, 16'h00C8);
		rd(timer1_pkg::ADDR_CMPA_LO, 8'hC8);
		repeat (600) @(posedge mclk);
		window();
		`CHK(high_a > 12'h18D && high_a < 12'h193, 1'b1)
		wr16(timer1_pkg::ADDR_CMPA_LO, 16'h0000);
		wr16(timer1_pkg::ADDR_CMPB_LO, 16'h0000);
		repeat (600) @(posedge mclk);
		window();
		`CHK(high_a, 12'h000)
		`CHK(high_b, 12'h1FE)
		wr(timer1_pkg::ADDR_CTRL_A, 8'h51);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		`CHK(pwm_oe_n_a, 1'b1)
		`CHK(pin_a, 1'b0)
	endtask : pwm_tests
	task automatic period_tests();
		wr16(timer1_pkg::ADDR_CMPA_LO, 16'h0010);
		for (int s = 1; s < 4; s++) begin
			wr(timer1_pkg::ADDR_CTRL_A, 8'hB0 | 8'(s));
			rise();
			rise();
			t0 = cycles;
			rise();
			`CHK(cycles - t0, 2 * ((1 << (s + 7)) - 1))
		end
	endtask : period_tests
	task automatic irq_tests();
		wr(timer1_pkg::ADDR_CTRL_A, 8'hB1);
		wr16(timer1_pkg::ADDR_CNT_LO, 16'h0000);
		wr(timer1_pkg::ADDR_IRQ_EN, 8'h01);
		global_irq_en <= 1'b1;
		wr(timer1_pkg::ADDR_FLAGS, 8'h0F);
		repeat (540) @(posedge mclk);
		rd(timer1_pkg::ADDR_FLAGS, 8'h11, 8'h11);
		`CHK(irq, 1'b1)
		@(posedge mclk);
		global_irq_en <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		`CHK(irq, 1'b0)
	endtask : irq_tests
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		capture_tests();
		pwm_tests();
		period_tests();
		irq_tests();
		tally_and_finish();
	end
endmodule : timer1_pwm_input_capture_bench
